//--- verilog/rxpps_pkg.sv
// rxpps_pkg: register map, field positions and reset values for the receive port paging block
// assumes an 8-bit register address space served by the device's I2C register clock
package rxpps_pkg;

    // register offsets
    localparam logic [7:0] RXPPS_PAGE_SELECT_ADDR = 8'h4c;
    localparam logic [7:0] RXPPS_STATUS_ONE_ADDR  = 8'h4d;

    // paged receiver register windows
    localparam logic [7:0] RXPPS_PAGED_A_LOW      = 8'h4d;
    localparam logic [7:0] RXPPS_PAGED_A_HIGH     = 8'h7f;
    localparam logic [7:0] RXPPS_PAGED_B_LOW      = 8'hd0;
    localparam logic [7:0] RXPPS_PAGED_B_HIGH     = 8'hdf;

    // receive_port_page_select fields
    localparam int         RXPPS_PHYS_PORT_LSB    = 6;
    localparam int         RXPPS_READ_PORT_LSB    = 4;
    localparam int         RXPPS_WRITE_EN_LSB     = 0;

    // receive_port_status_one fields
    localparam int         RXPPS_STS_PORT_LSB     = 6;
    localparam int         RXPPS_STS_CRC_BIT      = 5;

    // sizes and reset values
    localparam int         RXPPS_NUM_RX_PORTS     = 4;
    localparam logic [1:0] RXPPS_LOCAL_READ_RESET = 2'h0;
    localparam logic [3:0] RXPPS_LOCAL_WRITE_RESET = 4'h0;
    localparam logic [1:0] RXPPS_LOCAL_PHYS_PORT  = 2'h0;
    localparam logic [7:0] RXPPS_UNMAPPED_DATA    = 8'h00;

    // cycles from access strobe to answer
    localparam int         RXPPS_ACCESS_LATENCY   = 2;

endpackage

//--- verilog/rxpps_page_select.sv
// rxpps_page_select: per-source paging of the four receive port register blocks,
// the page select register and the selected-port part of the first status register
// assumes the i2c slave and back-channel slaves hand over decoded accesses on clk_in,
// and that the per-port register blocks answer reads combinationally
//
// Functional notes
// - paged ranges follow the current port selection
// - bits 5:4 pick the port for reads
// - bits 3:0 enable writes per port, broadcast
// - enable bit 0 blocks, 1 passes writes
// - read port resets local 0, remote own port
// - write enables reset local 0, remote own bit
// - bits 7:6 read 0 locally, port remotely
// - each access source keeps its own page
// - status bits 7:6 report selected read port
// - status bit 5 crc fault, clear on read
`timescale 1ns/1ps

module rxpps_page_select
    import rxpps_pkg::*;
#(
    parameter int NUM_LOCAL = 2
) (
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    input  wire logic                      access_valid_in,
    input  wire logic                      access_write_in,
    input  wire logic [$clog2(NUM_LOCAL + RXPPS_NUM_RX_PORTS)-1:0] access_source_in,
    input  wire logic [7:0]                access_addr_in,
    input  wire logic [7:0]                access_wdata_in,
    output logic                           access_ack_out,
    output logic [7:0]                     access_rdata_out,
    input  wire logic [3:0]                crc_fault_in,
    output logic [3:0]                     port_write_out,
    output logic                           port_read_out,
    output logic [1:0]                     port_select_out,
    output logic [7:0]                     port_addr_out,
    output logic [7:0]                     port_wdata_out,
    input  wire logic [4*8-1:0]            port_rdata_in
);

    localparam int NUM_SOURCES = NUM_LOCAL + RXPPS_NUM_RX_PORTS;
    localparam int SRC_W       = $clog2(NUM_SOURCES);

    if (NUM_LOCAL < 1 || NUM_LOCAL > 4) begin : g_check
        $error("rxpps_page_select: NUM_LOCAL must be 1 to 4");
    end

    typedef struct packed {
        logic [NUM_SOURCES-1:0][1:0] read_port;
        logic [NUM_SOURCES-1:0][3:0] write_en;
        logic [3:0]                  crc_fault;
        logic                        req_valid;
        logic                        req_write;
        logic                        req_paged;
        logic                        req_status;
        logic [7:0]                  local_data;
        logic [3:0]                  port_write;
        logic                        port_read;
        logic [1:0]                  port_sel;
        logic [7:0]                  port_addr;
        logic [7:0]                  port_wdata;
        logic                        ack;
        logic [7:0]                  rdata;
    } rxpps_state_type;

    // sources below NUM_LOCAL are local i2c, the rest are back channels of ports 0..3
    function automatic logic is_remote(input int src);
        is_remote = (src >= NUM_LOCAL);
    endfunction

    function automatic logic [1:0] source_port(input int src);
        source_port = is_remote(src) ? 2'(src - NUM_LOCAL) : RXPPS_LOCAL_PHYS_PORT;
    endfunction

    function automatic logic is_paged(input logic [7:0] addr);
        is_paged = (addr >= RXPPS_PAGED_A_LOW && addr <= RXPPS_PAGED_A_HIGH) ||
                   (addr >= RXPPS_PAGED_B_LOW && addr <= RXPPS_PAGED_B_HIGH);
    endfunction

    // constant reset image; remote sources start paged onto their own port
    function automatic rxpps_state_type reset_state();
        rxpps_state_type r;
        r = '0;
        for (int s = 0; s < NUM_SOURCES; s++) begin
            if (is_remote(s)) begin
                r.read_port[s] = source_port(s);
                r.write_en[s]  = 4'(1) << source_port(s);
            end else begin
                r.read_port[s] = RXPPS_LOCAL_READ_RESET;
                r.write_en[s]  = RXPPS_LOCAL_WRITE_RESET;
            end
        end
        return r;
    endfunction

    localparam rxpps_state_type RESET_STATE = reset_state();

    rxpps_state_type state;
    rxpps_state_type next_state;

    always_comb begin
        int          src;
        logic        src_ok;
        logic [1:0]  sel;
        logic [3:0]  crc_clear;
        src       = int'(access_source_in);
        src_ok    = (src < NUM_SOURCES);
        sel       = 2'h0;
        crc_clear = 4'h0;
        next_state = state;

        // answer stage: one cycle after the port strobes
        next_state.ack   = state.req_valid;
        next_state.rdata = RXPPS_UNMAPPED_DATA;
        if (state.req_valid && !state.req_write) begin
            if (state.req_paged) begin
                next_state.rdata = port_rdata_in[{state.port_sel, 3'b000} +: 8];
            end else begin
                next_state.rdata = state.local_data;
            end
            if (state.req_status) begin
                next_state.rdata[RXPPS_STS_PORT_LSB +: 2] = state.port_sel;
                next_state.rdata[RXPPS_STS_CRC_BIT] = state.crc_fault[state.port_sel];
                crc_clear[state.port_sel] = 1'b1;
            end
        end

        // a fault arriving with the clearing read stays set
        for (int p = 0; p < RXPPS_NUM_RX_PORTS; p++) begin
            if (crc_clear[p]) begin
                next_state.crc_fault[p] = 1'b0;
            end
            if (crc_fault_in[p]) begin
                next_state.crc_fault[p] = 1'b1;
            end
        end

        // request stage
        next_state.req_valid  = access_valid_in && src_ok;
        next_state.req_write  = access_write_in;
        next_state.req_paged  = 1'b0;
        next_state.req_status = 1'b0;
        next_state.local_data = RXPPS_UNMAPPED_DATA;
        next_state.port_write = 4'h0;
        next_state.port_read  = 1'b0;
        if (access_valid_in && src_ok) begin
            sel = state.read_port[src];
            next_state.port_sel   = sel;
            next_state.port_addr  = access_addr_in;
            next_state.port_wdata = access_wdata_in;
            if (is_paged(access_addr_in)) begin
                next_state.req_paged = 1'b1;
                if (access_write_in) begin
                    // no enable set leaves every block untouched, still acked
                    next_state.port_write = state.write_en[src];
                end else begin
                    next_state.port_read  = 1'b1;
                    next_state.req_status = (access_addr_in == RXPPS_STATUS_ONE_ADDR);
                end
            end else if (access_addr_in == RXPPS_PAGE_SELECT_ADDR) begin
                if (access_write_in) begin
                    // only the writing source's page moves
                    next_state.read_port[src] =
                        access_wdata_in[RXPPS_READ_PORT_LSB +: 2];
                    next_state.write_en[src] =
                        access_wdata_in[RXPPS_WRITE_EN_LSB +: 4];
                end else begin
                    next_state.local_data[RXPPS_PHYS_PORT_LSB +: 2] =
                        source_port(src);
                    next_state.local_data[RXPPS_READ_PORT_LSB +: 2] =
                        state.read_port[src];
                    next_state.local_data[RXPPS_WRITE_EN_LSB +: 4] =
                        state.write_en[src];
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // everything facing out comes straight from flip-flops
    assign access_ack_out   = state.ack;
    assign access_rdata_out = state.rdata;
    assign port_write_out   = state.port_write;
    assign port_read_out    = state.port_read;
    assign port_select_out  = state.port_sel;
    assign port_addr_out    = state.port_addr;
    assign port_wdata_out   = state.port_wdata;

endmodule

//--- sim/rxpps_page_select_monitor.sv
// rxpps_page_select_monitor: timing and field checks at the paging block ports
// assumes a bind into rxpps_page_select, one clock domain
`timescale 1ns/1ps
module rxpps_page_select_monitor #(parameter int NUM_LOCAL = 2) (
    input logic        clk_in, reset_in, access_valid_in, access_write_in, access_ack_out,
    input logic [2:0]  access_source_in,
    input logic [7:0]  access_addr_in, access_rdata_out, port_addr_out,
    input logic [3:0]  port_write_out,
    input logic        port_read_out,
    input logic [1:0]  port_select_out,
    input logic [31:0] port_rdata_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_take; access_valid_in && access_source_in < NUM_LOCAL + 4; endsequence
    sequence s_rd(a); s_take ##0 !access_write_in && access_addr_in == a; endsequence
    a_ack_latency: assert property (s_take |-> ##2 access_ack_out)
        else $error("ack late");
    a_wr_cause: assert property (|port_write_out |->
        $past(access_valid_in && access_write_in)) else $error("stray write strobe");
    a_rd_strobe: assert property (s_rd(8'h4d) |=> port_read_out)
        else $error("no read strobe");
    a_strobe_range: assert property (port_read_out || |port_write_out |->
        port_addr_out inside {[8'h4d:8'h7f], [8'hd0:8'hdf]}) else $error("strobe off page");
    a_local_phys: assert property (s_rd(8'h4c) ##0 access_source_in < NUM_LOCAL |->
        ##2 access_rdata_out[7:6] == 2'h0) else $error("local port field set");
    a_status_port: assert property (s_rd(8'h4d) |->
        ##2 access_rdata_out[7:6] == $past(port_select_out)) else $error("status port");
    a_read_pass: assert property (port_read_out && port_addr_out != 8'h4d |=>
        access_rdata_out == $past(port_rdata_in[port_select_out*8 +: 8])) else $error("rd data");
    a_write_quiet: assert property (s_take ##0 access_write_in |->
        ##2 access_rdata_out == 8'h00) else $error("write data not 0");
endmodule
bind rxpps_page_select rxpps_page_select_monitor #(.NUM_LOCAL(NUM_LOCAL))
    rxpps_page_select_monitor_i (.*);

//--- sim/rxpps_port_blocks.sv
// rxpps_port_blocks: four receive port register blocks, one byte per offset
// assumes strobes from the paging block on the same clock; reads answer at once
`timescale 1ns/1ps
module rxpps_port_blocks (
    input  wire logic        clk_in,
    input  wire logic [3:0]  port_write_in,
    input  wire logic [7:0]  port_addr_in, port_wdata_in,
    output logic      [31:0] port_rdata_out
);
    logic [7:0] regs [4][256] = '{default: 8'h00};
    always @(posedge clk_in)
        foreach (regs[p]) if (port_write_in[p]) regs[p][port_addr_in] <= port_wdata_in;
    always_comb foreach (regs[p]) port_rdata_out[p*8 +: 8] = regs[p][port_addr_in];
endmodule

//--- sim/rxpps_page_select_bench.sv
// rxpps_page_select_bench: directed scenarios for the receive port paging block
// assumes two local sources, back channel of rx port p on source 2 + p
`timescale 1ns/1ps
`define CHK(g, e) samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %0t: got %h expected %h", $time, g, e); end
module rxpps_page_select_bench;
    logic clk_in = 1'b0, reset_in = 1'b1, access_valid_in = 1'b0, access_write_in = 1'b0;
    logic [2:0]  access_source_in = 3'h0;
    logic [7:0]  access_addr_in = 8'h00, access_wdata_in = 8'h00;
    logic [3:0]  crc_fault_in = 4'h0, port_write_out;
    logic        access_ack_out, port_read_out;
    logic [7:0]  access_rdata_out, port_addr_out, port_wdata_out;
    logic [1:0]  port_select_out;
    logic [31:0] port_rdata_in;
    int          miscompares = 0, samples_checked = 0;
    rxpps_page_select rxpps_page_select_i (.*);
    rxpps_port_blocks rxpps_port_blocks_i (.clk_in, .port_write_in(port_write_out),
        .port_addr_in(port_addr_out), .port_wdata_in(port_wdata_out), .port_rdata_out(port_rdata_in));
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle strobe, then a bounded wait for the ack
    task automatic acc(logic [2:0] s, logic w, logic [7:0] a, d, output logic [7:0] r);
        int n;
        @(posedge clk_in);
        {access_valid_in, access_write_in, access_source_in} <= {1'b1, w, s};
        {access_addr_in, access_wdata_in} <= {a, d};
        @(posedge clk_in);
        access_valid_in <= 1'b0;
        for (n = 0; n < 4 && access_ack_out !== 1'b1; n++) @(posedge clk_in) #1;
        miscompares += int'(n == 4);
        if (n == 4) test_done();
        r = access_rdata_out;
    endtask
    task automatic t_reset_pages();
        logic [7:0] r;
        for (int s = 0; s < 6; s++) begin
            acc(3'(s), 1'b0, 8'h4c, 8'h00, r);
            `CHK(r, s < 2 ? 8'h00 : {2'(s - 2), 2'(s - 2), 4'(1 << (s - 2))})
        end
    endtask
    task automatic t_broadcast();
        logic [7:0] r;
        acc(3'h0, 1'b1, 8'h4c, 8'hf5, r);
        acc(3'h0, 1'b0, 8'h4c, 8'h00, r);
        `CHK(r, 8'h35)
        acc(3'h3, 1'b0, 8'h4c, 8'h00, r);
        `CHK(r, 8'h52)
        acc(3'h0, 1'b1, 8'h50, 8'ha5, r);
        // source 1 has no enables, so this write must leave every port alone
        acc(3'h1, 1'b1, 8'h50, 8'h3c, r);
        for (int p = 0; p < 4; p++) begin
            acc(3'h0, 1'b1, 8'h4c, {2'h0, 2'(p), 4'h0}, r);
            acc(3'h0, 1'b0, 8'h50, 8'h00, r);
            `CHK(r, p[0] ? 8'h00 : 8'ha5)
        end
    endtask
    task automatic t_crc_flag();
        logic [7:0] r;
        @(posedge clk_in);
        crc_fault_in <= 4'h2;
        @(posedge clk_in);
        crc_fault_in <= 4'h0;
        acc(3'h3, 1'b0, 8'h4d, 8'h00, r);
        `CHK(r, 8'h60)
        acc(3'h3, 1'b0, 8'h4d, 8'h00, r);
        `CHK(r, 8'h40)
    endtask
    initial forever #4 clk_in = ~clk_in;
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset_pages();
        t_broadcast();
        t_crc_flag();
        test_done();
    end
endmodule
